// ### src/qsf_pkg_buf.sv
// Package of constants and the two-entry receive word buffer
`timescale 1ns/1ps
`default_nettype none

package qsf_pkg;
  // Core clock
  localparam int CORE_CLK_PERIOD_NS = 100;
  localparam int CORE_CLK_HZ = 1000000000 / CORE_CLK_PERIOD_NS;
  // Word and frame limits and field widths
  localparam int MAX_WORD_BITS = 128;
  localparam int MAX_WORDS = 4096;
  localparam int LEN_W = 7;
  localparam int CNT_W = 12;
  localparam int DLY_W = 2;
  localparam int DIV_W = 8;
  localparam int TMR_W = 12;
  // Lane modes
  localparam logic [1:0] LANE_SINGLE = 2'h0;
  localparam logic [1:0] LANE_DUAL = 2'h1;
  localparam logic [1:0] LANE_QUAD = 2'h2;
  // Serial clock shaping: minimum period in core clocks, tail and lead in serial clock periods
  localparam int MIN_PERIOD_CYCLES = 2;
  localparam int TAIL_PERIODS = 2;
  localparam int LEAD_EXTRA_PERIODS = 1;
  // Reset values and receive buffer depth
  localparam logic RST_SCLK = 1'b0;
  localparam logic RST_CS_B = 1'b1;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [2:0] {
    QSF_IDLE = 3'h0,
    QSF_LEAD = 3'h1,
    QSF_HIGH = 3'h3,
    QSF_LOW = 3'h2,
    QSF_TAIL = 3'h6
  } qsf_state_t;
endpackage

module qsf_word_buf #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int OCC_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [OCC_W-1:0] occ, next_occ;
  logic push, pop;

  assign o_in_ready = (occ != OCC_W'(DEPTH));
  assign o_out_valid = (occ != '0);
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      next_mem[i] = mem[i];
    end
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_mem[wr_ptr] = i_in_data;
      next_wr_ptr = (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    next_occ = occ + OCC_W'(push) - OCC_W'(pop);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      wr_ptr <= '0;
      rd_ptr <= '0;
      occ <= '0;
    end else begin
      mem <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      occ <= next_occ;
    end
  end
endmodule

`default_nettype wire

// ### src/qsf_controller.sv
// Quad serial flash controller: frame sequencer, serial clock divider, lane shifter
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Always controller: drives serial clock and chip select, never answers as peripheral.
// - Reads over one, two or four data lines, chosen by lane mode.
// - Control and status are plain ports here, reachable directly by the processor.
// - Word length programmable from 1 to 128 bits.
// - Frame holds 1 to 4096 words; chip select stays active throughout.
// - Optional event per word and per frame, each separately enabled.
// - Chip select to first data gap programmable from 0 to 3 clocks.
// - Clock mode zero: clock idles low, phase zero.
// - Incoming data sampled on the falling serial clock edge.
// - Divider: zero or odd gives equal halves; even gives (v/2)/(v+1) high.
// - Chip select released two clock periods after the last falling edge.
// - Output data line changes with the falling serial clock edge.
// - First output bit presented one period before the first falling edge.
module qsf_controller
  import qsf_pkg::*;
#(
  parameter int DIV_WIDTH = DIV_W
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Frame control
  input wire logic i_start,
  input wire logic i_word_write,
  input wire logic [1:0] i_lane_mode,
  input wire logic [LEN_W-1:0] i_word_len_m1,
  input wire logic [CNT_W-1:0] i_word_count_m1,
  input wire logic [DIV_WIDTH-1:0] i_serial_clock_divide_value,
  input wire logic [DLY_W-1:0] i_select_to_clock_delay,
  input wire logic i_word_event_en,
  input wire logic i_frame_event_en,
  // Write word source
  input wire logic [MAX_WORD_BITS-1:0] i_tx_word,
  output logic o_tx_take,
  // Read word sink
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  output logic [MAX_WORD_BITS-1:0] o_rx_data,
  // Status and events
  output logic o_busy,
  output logic o_word_done,
  output logic o_frame_done,
  // Serial pins
  output logic o_sclk,
  output logic o_cs_b,
  output logic [3:0] o_data_out,
  output logic [3:0] o_data_oe,
  input wire logic [3:0] i_data_in
);
  localparam int PER_W = DIV_WIDTH + 1;

  function automatic logic [MAX_WORD_BITS-1:0] shift_in(input logic [MAX_WORD_BITS-1:0] word,
                                                        input logic [3:0] d, input logic [1:0] mode);
    logic [MAX_WORD_BITS-1:0] r;
    r = {word[MAX_WORD_BITS-2:0], d[1]};
    if (mode == LANE_DUAL) begin
      r = {word[MAX_WORD_BITS-3:0], d[1], d[0]};
    end else if (mode == LANE_QUAD) begin
      r = {word[MAX_WORD_BITS-5:0], d[3], d[2], d[1], d[0]};
    end
    return r;
  endfunction

  function automatic logic [LEN_W:0] lane_bits(input logic [1:0] mode);
    logic [LEN_W:0] r;
    r = (LEN_W + 1)'(1);
    if (mode == LANE_DUAL) begin
      r = (LEN_W + 1)'(2);
    end else if (mode == LANE_QUAD) begin
      r = (LEN_W + 1)'(4);
    end
    return r;
  endfunction

  function automatic logic [PER_W-1:0] period_of(input logic [DIV_WIDTH-1:0] div);
    logic [PER_W-1:0] r;
    r = PER_W'(div) + 1'b1;
    if (div == '0) begin
      r = PER_W'(MIN_PERIOD_CYCLES);
    end
    return r;
  endfunction

  // Input synchroniser for the data pins
  logic [3:0] din_meta, din_sync;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      din_meta <= '0;
      din_sync <= '0;
    end else begin
      din_meta <= i_data_in;
      din_sync <= din_meta;
    end
  end

  // Sequencer state
  qsf_state_t state, next_state;
  logic [TMR_W-1:0] tmr, next_tmr;
  logic [LEN_W:0] bits, next_bits;
  logic [CNT_W-1:0] words, next_words;
  logic [MAX_WORD_BITS-1:0] rx_sh, next_rx_sh, tx_sh, next_tx_sh;
  logic sclk, next_sclk, cs_b, next_cs_b, drive, next_drive;
  logic word_ev, next_word_ev, frame_ev, next_frame_ev;
  logic cfg_write, next_cfg_write, cfg_word_en, next_cfg_word_en, cfg_frame_en, next_cfg_frame_en;
  logic [1:0] cfg_mode, next_cfg_mode;
  logic [LEN_W-1:0] cfg_len, next_cfg_len;
  logic [CNT_W-1:0] cfg_count, next_cfg_count;
  logic [DIV_WIDTH-1:0] cfg_div, next_cfg_div;

  logic [PER_W-1:0] per, hi_len, lo_len, st_per, st_lo;
  logic [LEN_W:0] bits_after;
  logic [MAX_WORD_BITS-1:0] rx_word;
  logic buf_ready, push, take, last_bit;

  assign per = period_of(cfg_div);
  assign hi_len = per >> 1;
  assign lo_len = per - hi_len;
  assign st_per = period_of(i_serial_clock_divide_value);
  assign st_lo = st_per - (st_per >> 1);
  assign bits_after = bits + lane_bits(cfg_mode);
  assign last_bit = (bits_after > (LEN_W + 1)'(cfg_len));
  assign rx_word = shift_in(rx_sh, din_sync, cfg_mode);

  always_comb begin
    next_state = state;
    next_tmr = tmr;
    next_bits = bits;
    next_words = words;
    next_rx_sh = rx_sh;
    next_tx_sh = tx_sh;
    next_sclk = sclk;
    next_cs_b = cs_b;
    next_drive = drive;
    next_word_ev = 1'b0;
    next_frame_ev = 1'b0;
    next_cfg_write = cfg_write;
    next_cfg_word_en = cfg_word_en;
    next_cfg_frame_en = cfg_frame_en;
    next_cfg_mode = cfg_mode;
    next_cfg_len = cfg_len;
    next_cfg_count = cfg_count;
    next_cfg_div = cfg_div;
    push = 1'b0;
    take = 1'b0;
    case (state)
      QSF_IDLE: begin
        next_sclk = 1'b0;
        next_cs_b = 1'b1;
        next_drive = 1'b0;
        if (i_start) begin
          next_cfg_write = i_word_write;
          next_cfg_word_en = i_word_event_en;
          next_cfg_frame_en = i_frame_event_en;
          next_cfg_mode = i_lane_mode;
          next_cfg_len = i_word_len_m1;
          next_cfg_count = i_word_count_m1;
          next_cfg_div = i_serial_clock_divide_value;
          next_cs_b = 1'b0;
          // Lead: dd whole periods plus the low half before the first rise
          next_tmr = TMR_W'(i_select_to_clock_delay) * TMR_W'(st_per) + TMR_W'(st_lo);
          next_bits = '0;
          next_words = '0;
          next_rx_sh = '0;
          next_tx_sh = i_tx_word << (MAX_WORD_BITS - 1 - int'(i_word_len_m1));
          take = i_word_write;
          next_drive = i_word_write && (i_lane_mode == LANE_SINGLE) &&
                       (i_select_to_clock_delay == '0);
          next_state = QSF_LEAD;
        end
      end
      QSF_LEAD: begin
        if (tmr == TMR_W'(1)) begin
          if (buf_ready || cfg_write) begin
            next_sclk = 1'b1;
            next_tmr = TMR_W'(hi_len);
            next_state = QSF_HIGH;
          end
        end else begin
          next_tmr = tmr - 1'b1;
          // Drive from one full period before the first falling edge
          if (next_tmr <= TMR_W'(lo_len)) begin
            next_drive = cfg_write && (cfg_mode == LANE_SINGLE);
          end
        end
      end
      QSF_HIGH: begin
        if (tmr == TMR_W'(1)) begin
          // Falling edge: sample and launch together
          next_sclk = 1'b0;
          next_tmr = TMR_W'(lo_len);
          next_rx_sh = rx_word;
          next_tx_sh = tx_sh << 1;
          next_bits = bits_after;
          next_state = QSF_LOW;
          if (last_bit) begin
            push = !cfg_write;
            next_word_ev = cfg_word_en;
            next_bits = '0;
            next_rx_sh = '0;
            if (words == cfg_count) begin
              next_frame_ev = cfg_frame_en;
              next_drive = 1'b0;
              next_tmr = TMR_W'(TAIL_PERIODS) * TMR_W'(per);
              next_state = QSF_TAIL;
            end else begin
              next_words = words + 1'b1;
              next_tx_sh = i_tx_word << (MAX_WORD_BITS - 1 - int'(cfg_len));
              take = cfg_write;
            end
          end
        end else begin
          next_tmr = tmr - 1'b1;
        end
      end
      QSF_LOW: begin
        if (tmr == TMR_W'(1)) begin
          // Hold the clock low at a word boundary while the buffer is full
          if ((bits != '0) || buf_ready || cfg_write) begin
            next_sclk = 1'b1;
            next_tmr = TMR_W'(hi_len);
            next_state = QSF_HIGH;
          end
        end else begin
          next_tmr = tmr - 1'b1;
        end
      end
      QSF_TAIL: begin
        if (tmr == TMR_W'(1)) begin
          next_cs_b = 1'b1;
          next_state = QSF_IDLE;
        end else begin
          next_tmr = tmr - 1'b1;
        end
      end
      default: begin
        next_state = QSF_IDLE;
        next_cs_b = 1'b1;
        next_sclk = 1'b0;
        next_drive = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= QSF_IDLE;
      tmr <= '0;
      bits <= '0;
      words <= '0;
      rx_sh <= '0;
      tx_sh <= '0;
      sclk <= RST_SCLK;
      cs_b <= RST_CS_B;
      drive <= 1'b0;
      word_ev <= 1'b0;
      frame_ev <= 1'b0;
      cfg_write <= 1'b0;
      cfg_word_en <= 1'b0;
      cfg_frame_en <= 1'b0;
      cfg_mode <= LANE_SINGLE;
      cfg_len <= '0;
      cfg_count <= '0;
      cfg_div <= '0;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      bits <= next_bits;
      words <= next_words;
      rx_sh <= next_rx_sh;
      tx_sh <= next_tx_sh;
      sclk <= next_sclk;
      cs_b <= next_cs_b;
      drive <= next_drive;
      word_ev <= next_word_ev;
      frame_ev <= next_frame_ev;
      cfg_write <= next_cfg_write;
      cfg_word_en <= next_cfg_word_en;
      cfg_frame_en <= next_cfg_frame_en;
      cfg_mode <= next_cfg_mode;
      cfg_len <= next_cfg_len;
      cfg_count <= next_cfg_count;
      cfg_div <= next_cfg_div;
    end
  end

  qsf_word_buf #(
    .WIDTH(MAX_WORD_BITS),
    .DEPTH(BUF_DEPTH)
  ) u_rx_buf (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_in_valid(push),
    .o_in_ready(buf_ready),
    .i_in_data(rx_word),
    .o_out_valid(o_rx_valid),
    .i_out_ready(i_rx_ready),
    .o_out_data(o_rx_data)
  );

  assign o_tx_take = take;
  assign o_busy = (state != QSF_IDLE);
  assign o_word_done = word_ev;
  assign o_frame_done = frame_ev;
  assign o_sclk = sclk;
  assign o_cs_b = cs_b;
  // Line 0 carries write data; lines 1 to 3 are always read lanes
  assign o_data_out = {3'h0, tx_sh[MAX_WORD_BITS-1]};
  assign o_data_oe = {3'h0, drive};
endmodule

`default_nettype wire

// ### sim/qsf_controller_asserts.sv
// Checker of serial pin timing, events and receive buffer handshake
`timescale 1ns/1ps
`default_nettype none
module qsf_controller_asserts
  import qsf_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_start,
  input wire logic i_rx_ready,
  input wire logic o_rx_valid,
  input wire logic [MAX_WORD_BITS-1:0] o_rx_data,
  input wire logic o_busy,
  input wire logic o_word_done,
  input wire logic o_frame_done,
  input wire logic o_sclk,
  input wire logic o_cs_b,
  input wire logic [3:0] o_data_out,
  input wire logic [3:0] o_data_oe
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  logic [7:0] low_run;
  logic [7:0] next_low_run;
  // Cycles the clock has stayed low inside a frame
  always_comb begin
    next_low_run = low_run;
    if (o_sclk || o_cs_b) next_low_run = 8'h00;
    else if (low_run != 8'hFF) next_low_run = low_run + 8'h01;
  end
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) low_run <= 8'h00;
    else low_run <= next_low_run;
  end
  sequence s_take; i_start && !o_busy; endsequence
  sequence s_open; !o_cs_b && o_busy; endsequence
  chk_start_opens: assert property (s_take |=> s_open)
    else $error("start did not open a frame");
  chk_idle_low: assert property (o_cs_b |-> !o_sclk)
    else $error("clock active with select high");
  chk_busy_sel: assert property (!o_busy |-> o_cs_b)
    else $error("select low while idle");
  chk_lead_low: assert property ($fell(o_cs_b) |-> !o_sclk ##1 !$fell(o_sclk))
    else $error("clock not low at frame open");
  chk_tail_gap: assert property ($rose(o_cs_b) |-> $past(low_run) >= 8'h03)
    else $error("select released too soon");
  chk_upper_off: assert property (o_data_oe[3:1] == 3'h0 && o_data_out[3:1] == 3'h0)
    else $error("upper data lines driven");
  chk_oe_sel: assert property (o_data_oe[0] |-> !o_cs_b)
    else $error("line driven outside frame");
  chk_out_fall: assert property (o_data_oe[0] && $past(o_data_oe[0]) && $changed(o_data_out[0]) |-> $fell(o_sclk))
    else $error("output bit moved off falling edge");
  chk_done_edge: assert property (o_word_done |-> $fell(o_sclk) ##1 !o_word_done)
    else $error("word event not at falling edge");
  chk_frame_word: assert property (o_frame_done |-> $fell(o_sclk) ##1 !o_cs_b)
    else $error("frame event not at last falling edge");
  chk_rx_hold: assert property (o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data))
    else $error("buffer output dropped while stalled");
endmodule
bind qsf_controller qsf_controller_asserts u_qsf_controller_asserts (.i_core_clk, .i_rst_b, .i_start,
  .i_rx_ready, .o_rx_valid, .o_rx_data, .o_busy, .o_word_done, .o_frame_done, .o_sclk, .o_cs_b,
  .o_data_out, .o_data_oe);
`default_nettype wire

// ### sim/qsf_flash_model.sv
// Serial flash model streaming a fixed bit pattern in clock mode zero
`timescale 1ns/1ps
`default_nettype none
module qsf_flash_model
  import qsf_pkg::*;
(
  input wire logic i_sclk,
  input wire logic i_cs_b,
  input wire logic [1:0] i_lanes,
  input wire logic i_slow,
  input wire logic [127:0] i_pattern,
  output logic [3:0] o_data
);
  int k;
  function automatic logic [3:0] pick(input int b);
    logic [3:0] v;
    v = ~o_data;
    case (i_lanes)
      LANE_DUAL: v[1:0] = {i_pattern[127 - b % 128], i_pattern[127 - (b + 1) % 128]};
      LANE_QUAD: for (int j = 0; j < 4; j++) v[3 - j] = i_pattern[127 - (b + j) % 128];
      default: v[1] = i_pattern[127 - b % 128];
    endcase
    return v;
  endfunction
  initial o_data = 4'h5;
  // First bits ready as select falls
  always @(negedge i_cs_b) begin
    k = 0;
    o_data = pick(0);
  end
  // Released lines do not hold their value
  always @(posedge i_cs_b) o_data = ~o_data;
  always @(negedge i_sclk) if (!i_cs_b) begin
    k = k + ((i_lanes == LANE_QUAD) ? 4 : (i_lanes == LANE_DUAL) ? 2 : 1);
    if (i_slow) #40;
    o_data = pick(k);
  end
endmodule
`default_nettype wire

// ### sim/tb_qsf_controller.sv
// Bench: read and write frames against the flash model
`timescale 1ns/1ps
`default_nettype none
module tb_qsf_controller
  import qsf_pkg::*;
;
  logic i_core_clk = 1'b0, i_rst_b = 1'b0, i_start = 1'b0, i_word_write = 1'b0, i_rx_ready = 1'b1;
  logic i_word_event_en = 1'b0, i_frame_event_en = 1'b0, slow = 1'b0, stall = 1'b0, ps = 1'b0, pc = 1'b1;
  logic po = 1'b0;
  int t_oe = 0, ntk = 0;
  logic [1:0] i_lane_mode = 2'h0, i_select_to_clock_delay = 2'h0;
  logic [LEN_W-1:0] i_word_len_m1 = 7'h00;
  logic [CNT_W-1:0] i_word_count_m1 = 12'h000;
  logic [7:0] i_serial_clock_divide_value = 8'h00;
  logic [127:0] i_tx_word = 128'h9E37_79B9_7F4A_7C15_F39C_C060_5CED_C834;
  logic [127:0] pat = 128'hC3A5_0F96_1E2D_B487_6A59_D2F0_3C81_E74B;
  logic [127:0] o_rx_data, wcap;
  logic o_tx_take, o_rx_valid, o_busy, o_word_done, o_frame_done, o_sclk, o_cs_b;
  logic [3:0] o_data_out, o_data_oe, mdat;
  wire logic [3:0] i_data_in;
  int mismatches = 0, n_tests = 0, cyc = 0, nf, nw, nfr, npop, len, t_csf, t_f1, t_lf, t_csr, t_r, t_f, hi, lo;
  assign i_data_in = (o_data_oe & o_data_out) | (~o_data_oe & mdat);
  qsf_controller u_qsf_controller (.i_core_clk, .i_rst_b, .i_start, .i_word_write, .i_lane_mode,
    .i_word_len_m1, .i_word_count_m1, .i_serial_clock_divide_value, .i_select_to_clock_delay,
    .i_word_event_en, .i_frame_event_en, .i_tx_word, .o_tx_take, .o_rx_valid, .i_rx_ready, .o_rx_data,
    .o_busy, .o_word_done, .o_frame_done, .o_sclk, .o_cs_b, .o_data_out, .o_data_oe, .i_data_in);
  qsf_flash_model u_qsf_flash_model (.i_sclk(o_sclk), .i_cs_b(o_cs_b), .i_lanes(i_lane_mode),
    .i_slow(slow), .i_pattern(pat), .o_data(mdat));
  initial forever #50 i_core_clk = ~i_core_clk;
  task automatic cmp_int(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      mismatches++;
      $display("BAD t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic cmp_vec(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  function automatic logic [127:0] expw(input int w);
    logic [127:0] v;
    v = '0;
    for (int j = 0; j < len; j++) v[len - 1 - j] = pat[127 - (w * len + j) % 128];
    return v;
  endfunction
  // Pin edge timestamps and ready pattern
  always @(negedge i_core_clk) begin
    cyc++;
    i_rx_ready <= !stall || (cyc % 48 == 0);
    if (o_sclk && !ps) begin
      t_r = cyc;
      wcap = {wcap[126:0], o_data_out[0]};
      if (nf > 0 && !stall) lo = cyc - t_f;
    end
    if (!o_sclk && ps) begin
      hi = cyc - t_r;
      t_f = cyc;
      t_lf = cyc;
      if (nf == 0) t_f1 = cyc;
      nf++;
    end
    if (!o_cs_b && pc) t_csf = cyc;
    if (o_cs_b && !pc) t_csr = cyc;
    if (o_word_done === 1'b1) nw++;
    if (o_frame_done === 1'b1) nfr++;
    if (o_data_oe[0] && !po) t_oe = cyc;
    po = o_data_oe[0];
    ps = o_sclk;
    pc = o_cs_b;
  end
  always @(posedge i_core_clk) if (o_rx_valid === 1'b1 && i_rx_ready === 1'b1) begin
    cmp_vec(o_rx_data, expw(npop));
    npop++;
  end
  // Words consumed from the write source
  always @(posedge i_core_clk) if (o_tx_take === 1'b1) ntk++;
  task automatic run_frame(input logic wr, input logic [1:0] ln, input int l, input int c, input int dv, input int dd);
    int p, lanes, guard;
    logic [127:0] m;
    p = (dv == 0) ? 2 : dv + 1;
    lanes = wr ? 1 : (ln == LANE_QUAD) ? 4 : (ln == LANE_DUAL) ? 2 : 1;
    m = (128'h1 << l) - 128'h1;
    len = l;
    nf = 0;
    nw = 0;
    nfr = 0;
    npop = 0;
    ntk = 0;
    guard = 0;
    @(negedge i_core_clk);
    i_word_write = wr;
    i_lane_mode = ln;
    i_word_len_m1 = 7'(l - 1);
    i_word_count_m1 = 12'(c - 1);
    i_serial_clock_divide_value = 8'(dv);
    i_select_to_clock_delay = 2'(dd);
    i_word_event_en = !wr;
    i_frame_event_en = (dd != 2);
    i_start = 1'b1;
    @(negedge i_core_clk);
    i_start = 1'b0;
    repeat (3) @(negedge i_core_clk);
    // Second start and new length while busy must be ignored
    i_start = 1'b1;
    i_word_len_m1 = 7'h00;
    @(negedge i_core_clk);
    i_start = 1'b0;
    while ((o_busy === 1'b1 || o_rx_valid === 1'b1) && guard < 30000) begin
      @(negedge i_core_clk);
      guard++;
    end
    if (guard >= 30000) mismatches++;
    repeat (2) @(negedge i_core_clk);
    cmp_int(nw, wr ? 0 : c);
    cmp_int(ntk, wr ? c : 0);
    if (wr) cmp_int(t_f1 - t_oe, p);
    cmp_int(nfr, (dd == 2) ? 0 : 1);
    cmp_int(nf, c * ((l + lanes - 1) / lanes));
    cmp_int(t_f1 - t_csf, (dd + 1) * p);
    cmp_int(t_csr - t_lf, 2 * p);
    cmp_int(hi, p / 2);
    if (!stall) cmp_int(lo, p - p / 2);
    if (wr) cmp_vec(wcap & m, i_tx_word & m);
    else cmp_int(npop, c);
    $display("frame end write=%0d lanes=%0d len=%0d words=%0d", wr, lanes, l, c);
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge i_core_clk);
    i_rst_b = 1'b1;
    run_frame(1'b0, LANE_SINGLE, 8, 3, 3, 0);
    slow = 1'b1;
    run_frame(1'b0, LANE_DUAL, 16, 2, 5, 3);
    slow = 1'b0;
    run_frame(1'b0, LANE_QUAD, 128, 1, 3, 1);
    run_frame(1'b0, 2'h3, 4, 2, 7, 0);
    run_frame(1'b1, LANE_SINGLE, 13, 3, 0, 2);
    run_frame(1'b1, LANE_SINGLE, 4, 2, 4, 0);
    run_frame(1'b1, LANE_SINGLE, 1, 4096, 1, 0);
    stall = 1'b1;
    run_frame(1'b0, LANE_SINGLE, 8, 5, 3, 0);
    stall = 1'b0;
    give_verdict;
  end
  initial begin
    #6000000;
    mismatches++;
    give_verdict;
  end
endmodule
`default_nettype wire
